// *** byte_rotator.sv ***
// right rotation of one byte by a three-bit count
// pure combinational, used on the cpu write path
`timescale 1ns/1ps
module byte_rotator
  import gfx_datapath_pkg::*;
(
  input  wire logic [7:0] data_in,
  input  wire logic [2:0] rotate_count,
  output logic      [7:0] data_out
);

  // doubled byte makes every rotation one slice
  logic [15:0] doubled;

  always_comb
  begin
    doubled  = {data_in, data_in};
    data_out = doubled[rotate_count +: 8];
  end

endmodule : byte_rotator

// *** color_comparator.sv ***
// per-pixel compare of four plane bytes against a reference color
// pure combinational, fed from the plane read bus
`timescale 1ns/1ps
module color_comparator
  import gfx_datapath_pkg::*;
(
  input  wire logic [31:0] plane_bytes,
  input  wire logic [3:0]  compare_reference,
  output logic      [7:0]  match
);

  // one pixel per bit position, one reference bit per map
  genvar p;
  generate
    for (p = 0; p < 8; p++)
    begin : g_pix
      assign match[p] = ({plane_bytes[24+p], plane_bytes[16+p], plane_bytes[8+p],
                          plane_bytes[p]} == compare_reference);
    end
  endgenerate

endmodule : color_comparator

// *** gfx_datapath_pkg.sv ***
// constants, field layouts and reset values of the plane write/read datapath
// assumes a host that reaches the registers through an index port and a data port
package gfx_datapath_pkg;

  localparam logic [15:0] INDEX_PORT        = 16'h03ce;
  localparam logic [15:0] DATA_PORT         = 16'h03cf;
  localparam logic [3:0]  IDX_FILL_VALUE    = 4'h0;
  localparam logic [3:0]  IDX_FILL_ENABLE   = 4'h1;
  localparam logic [3:0]  IDX_COMPARE_REF   = 4'h2;
  localparam logic [3:0]  IDX_ROTATE_LOGIC  = 4'h3;
  localparam logic [3:0]  IDX_READ_SELECT   = 4'h4;
  localparam logic [3:0]  IDX_MODE          = 4'h5;
  localparam logic [3:0]  IDX_BIT_MASK      = 4'h8;

  // field positions
  localparam int ROT_LSB  = 0;
  localparam int FUNC_LSB = 3;
  localparam int RD1_BIT  = 3;

  // reset values
  localparam logic [6:0] INDEX_RESET     = 7'h00;
  localparam logic [3:0] NIBBLE_RESET    = 4'h0;
  localparam logic [4:0] ROTATE_RESET    = 5'h00;
  localparam logic [1:0] RDSEL_RESET     = 2'h0;
  localparam logic [7:0] MASK_RESET      = 8'hff;
  localparam logic [2:0] MODE_RESET      = 3'h0;

  typedef enum logic [1:0]
  {
    FN_PASS = 2'b00,
    FN_AND  = 2'b01,
    FN_OR   = 2'b10,
    FN_XOR  = 2'b11
  } logic_fn_t;

  typedef enum logic [1:0]
  {
    WM_DIRECT = 2'b00,
    WM_LATCH  = 2'b01,
    WM_COLOR  = 2'b10,
    WM_FILL   = 2'b11
  } write_mode_t;

endpackage : gfx_datapath_pkg

// *** plane_datapath.sv ***
// graphics controller write/read datapath between host i/o and four planes
// assumes io strobes and memory strobes are single-cycle pulses on clock,
// memory read data valid in the cycle of mem_rd_strobe
`timescale 1ns/1ps
module plane_datapath
  import gfx_datapath_pkg::*;
(
  input  wire logic        clock,
  input  wire logic        rst_n,
  input  wire logic [15:0] io_addr,
  input  wire logic [7:0]  io_wdata,
  input  wire logic        io_wr,
  input  wire logic        io_rd,
  output logic      [7:0]  io_rdata,
  input  wire logic        mem_wr_strobe,
  input  wire logic        mem_rd_strobe,
  input  wire logic [7:0]  cpu_wdata,
  input  wire logic [31:0] plane_rdata,
  input  wire logic [3:0]  plane_write_enables,
  input  wire logic        chain_four_setting,
  input  wire logic [1:0]  chain_plane,
  output logic      [31:0] plane_wdata,
  output logic      [31:0] plane_bit_we,
  output logic             plane_wr_pulse,
  output logic      [7:0]  cpu_rdata
);

  // register file
  logic [6:0]  index;
  logic [3:0]  fill_value;
  logic [3:0]  fill_enable_bits;
  logic [3:0]  compare_reference;
  logic [4:0]  rotate_and_logic_op;
  logic [1:0]  read_plane_choice;
  logic [2:0]  mode_bits;
  logic [7:0]  per_bit_write_mask;
  logic [31:0] latches;

  logic [2:0]        rotate_count;
  logic_fn_t         logic_function_code;
  write_mode_t       write_mode_code;
  logic              compare_mode;
  logic [7:0]        rotated;
  logic [7:0]        match;
  logic [31:0]       next_wdata;
  logic [1:0]        eff_read_plane;

  assign rotate_count        = rotate_and_logic_op[ROT_LSB +: 3];
  assign logic_function_code = logic_fn_t'(rotate_and_logic_op[FUNC_LSB +: 2]);
  assign write_mode_code     = write_mode_t'(mode_bits[1:0]);
  assign compare_mode        = mode_bits[2];

  // index and data port writes
  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      index               <= INDEX_RESET;
      fill_value          <= NIBBLE_RESET;
      fill_enable_bits    <= NIBBLE_RESET;
      compare_reference   <= NIBBLE_RESET;
      rotate_and_logic_op <= ROTATE_RESET;
      read_plane_choice   <= RDSEL_RESET;
      mode_bits           <= MODE_RESET;
      per_bit_write_mask  <= MASK_RESET;
    end
    else if (io_wr && io_addr == INDEX_PORT)
      index <= io_wdata[6:0];
    else if (io_wr && io_addr == DATA_PORT && index[6:4] == 3'h0)
    begin
      case (index[3:0])
        IDX_FILL_VALUE:   fill_value          <= io_wdata[3:0];
        IDX_FILL_ENABLE:  fill_enable_bits    <= io_wdata[3:0];
        IDX_COMPARE_REF:  compare_reference   <= io_wdata[3:0];
        IDX_ROTATE_LOGIC: rotate_and_logic_op <= io_wdata[4:0];
        IDX_READ_SELECT:  read_plane_choice   <= io_wdata[1:0];
        IDX_MODE:         mode_bits           <= {io_wdata[RD1_BIT], io_wdata[1:0]};
        IDX_BIT_MASK:     per_bit_write_mask  <= io_wdata;
        default:          ;
      endcase
    end
  end

  // register readback, reserved bits read zero
  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
      io_rdata <= 8'h00;
    else if (io_rd && io_addr == INDEX_PORT)
      io_rdata <= {1'b0, index};
    else if (io_rd && io_addr == DATA_PORT && index[6:4] == 3'h0)
    begin
      case (index[3:0])
        IDX_FILL_VALUE:   io_rdata <= {4'h0, fill_value};
        IDX_FILL_ENABLE:  io_rdata <= {4'h0, fill_enable_bits};
        IDX_COMPARE_REF:  io_rdata <= {4'h0, compare_reference};
        IDX_ROTATE_LOGIC: io_rdata <= {3'h0, rotate_and_logic_op};
        IDX_READ_SELECT:  io_rdata <= {6'h00, read_plane_choice};
        IDX_MODE:         io_rdata <= {4'h0, mode_bits[2], 1'b0, mode_bits[1:0]};
        IDX_BIT_MASK:     io_rdata <= per_bit_write_mask;
        default:          io_rdata <= 8'h00;
      endcase
    end
    else
      io_rdata <= 8'h00;
  end

  // rotation ahead of everything else on the write path in write modes 0 and 3
  byte_rotator u_rot
  (
    .data_in      (cpu_wdata),
    .rotate_count (rotate_count),
    .data_out     (rotated)
  );

  color_comparator u_cmp
  (
    .plane_bytes       (plane_rdata),
    .compare_reference (compare_reference),
    .match             (match)
  );

  // per-plane write data: source select, then logical function
  always_comb
  begin
    logic [7:0] src;
    logic [7:0] lat;
    src        = 8'h00;
    lat        = 8'h00;
    next_wdata = 32'h0;
    for (int n = 0; n < 4; n++)
    begin
      src = 8'h00;
      lat = latches[8*n +: 8];
      case (write_mode_code)
        WM_DIRECT: src = fill_enable_bits[n] ? {8{fill_value[n]}} : rotated;
        WM_LATCH:  src = lat;
        WM_COLOR:  src = {8{cpu_wdata[n]}};
        WM_FILL:   src = {8{fill_value[n]}};
        default:   src = rotated;
      endcase
      if (write_mode_code != WM_LATCH)
      begin
        case (logic_function_code)
          FN_PASS: src = src;
          FN_AND:  src = src & lat;
          FN_OR:   src = src | lat;
          FN_XOR:  src = src ^ lat;
          default: src = src;
        endcase
      end
      next_wdata[8*n +: 8] = src;
    end
  end

  // registered write to the planes, plane enables gate it, bit mask gates it in all but latch-copy mode
  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      plane_wdata    <= 32'h0;
      plane_bit_we   <= 32'h0;
      plane_wr_pulse <= 1'b0;
    end
    else
    begin
      plane_wr_pulse <= mem_wr_strobe;
      plane_wdata    <= next_wdata;
      for (int n = 0; n < 4; n++)
      begin
        // latch-copy writes ignore the mask, rotated fill ANDs it in
        if (!mem_wr_strobe || !plane_write_enables[n])
          plane_bit_we[8*n +: 8] <= 8'h00;
        else if (write_mode_code == WM_LATCH)
          plane_bit_we[8*n +: 8] <= 8'hff;
        else if (write_mode_code == WM_FILL)
          plane_bit_we[8*n +: 8] <= per_bit_write_mask & rotated;
        else
          plane_bit_we[8*n +: 8] <= per_bit_write_mask;
      end
    end
  end

  // latches load on every display memory read
  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
      latches <= 32'h0;
    else if (mem_rd_strobe)
      latches <= plane_rdata;
  end

  // chain-four takes plane choice from the address side
  assign eff_read_plane = chain_four_setting ? chain_plane : read_plane_choice;

  // cpu read data registered, compare mode ignores read-map choice
  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
      cpu_rdata <= 8'h00;
    else if (mem_rd_strobe)
    begin
      if (compare_mode)
        cpu_rdata <= match;
      else
        cpu_rdata <= plane_rdata[8*eff_read_plane +: 8];
    end
  end

  a_latch_load: assert property (@(posedge clock) disable iff (!rst_n)
    mem_rd_strobe |=> latches == $past(plane_rdata))
    else $error("latches not loaded by read");

  a_compare_read: assert property (@(posedge clock) disable iff (!rst_n)
    (mem_rd_strobe && compare_mode) |=> cpu_rdata == $past(match))
    else $error("compare read wrong");

  a_map_read: assert property (@(posedge clock) disable iff (!rst_n)
    (mem_rd_strobe && !compare_mode && !chain_four_setting)
      |=> cpu_rdata == $past(plane_rdata[8*read_plane_choice +: 8]))
    else $error("map read wrong");

  a_plane_gate: assert property (@(posedge clock) disable iff (!rst_n)
    !plane_write_enables[0] |=> plane_bit_we[7:0] == 8'h00)
    else $error("disabled plane written");

  a_mask_protect: assert property (@(posedge clock) disable iff (!rst_n)
    (mem_wr_strobe && write_mode_code == WM_DIRECT)
      |=> (plane_bit_we[7:0] & ~$past(per_bit_write_mask)) == 8'h00)
    else $error("masked bit written");

  a_fill_data: assert property (@(posedge clock) disable iff (!rst_n)
    (write_mode_code == WM_DIRECT && fill_enable_bits[0]
      && logic_function_code == FN_PASS)
      |=> plane_wdata[7:0] == {8{$past(fill_value[0])}})
    else $error("fill value not used");

  a_rotate_data: assert property (@(posedge clock) disable iff (!rst_n)
    (write_mode_code == WM_DIRECT && !fill_enable_bits[1]
      && logic_function_code == FN_PASS)
      |=> plane_wdata[15:8] == $past(rotated))
    else $error("cpu data not used");

  a_latch_copy: assert property (@(posedge clock) disable iff (!rst_n)
    write_mode_code == WM_LATCH |=> plane_wdata == $past(latches))
    else $error("latch copy wrong");

  a_xor_func: assert property (@(posedge clock) disable iff (!rst_n)
    (write_mode_code == WM_COLOR && logic_function_code == FN_XOR)
      |=> plane_wdata[7:0] == ($past({8{cpu_wdata[0]}}) ^ $past(latches[7:0])))
    else $error("xor function wrong");

  a_write_pulse: assert property (@(posedge clock) disable iff (!rst_n)
    mem_wr_strobe |=> plane_wr_pulse ##1 !plane_wr_pulse || $past(mem_wr_strobe, 1))
    else $error("write pulse wrong");

  // rotation recomputed from cpu data here,
  // so a broken rotator cannot hide behind its own output
  a_rotate_first: assert property (@(posedge clock) disable iff (!rst_n)
    (write_mode_code == WM_DIRECT && !fill_enable_bits[2] && logic_function_code == FN_PASS)
      |=> plane_wdata[23:16] == $past(8'({cpu_wdata, cpu_wdata} >> rotate_count)))
    else $error("rotated data not used");

  a_and_after_rotate: assert property (@(posedge clock) disable iff (!rst_n)
    (write_mode_code == WM_DIRECT && !fill_enable_bits[3] && logic_function_code == FN_AND)
      |=> plane_wdata[31:24] == ($past(8'({cpu_wdata, cpu_wdata} >> rotate_count))
                                 & $past(latches[31:24])))
    else $error("and function not on rotated data");

  a_fill_mode_mask: assert property (@(posedge clock) disable iff (!rst_n)
    (mem_wr_strobe && write_mode_code == WM_FILL && plane_write_enables[0])
      |=> plane_bit_we[7:0]
        == $past(per_bit_write_mask & 8'({cpu_wdata, cpu_wdata} >> rotate_count)))
    else $error("fill mode enables wrong");

  a_chain_read: assert property (@(posedge clock) disable iff (!rst_n)
    (mem_rd_strobe && !compare_mode && chain_four_setting)
      |=> cpu_rdata == $past(plane_rdata[8*chain_plane +: 8]))
    else $error("chained read wrong");

  a_reg_idle: assert property (@(posedge clock) disable iff (!rst_n)
    !io_rd |=> io_rdata == 8'h00)
    else $error("register data not cleared");

  a_reserved_zero: assert property (@(posedge clock) disable iff (!rst_n)
    (io_rd && io_addr == DATA_PORT && index == 7'(IDX_ROTATE_LOGIC))
      |=> io_rdata[7:5] == 3'h0)
    else $error("reserved bits not zero");

  a_latch_all_bits: assert property (@(posedge clock) disable iff (!rst_n)
    (mem_wr_strobe && write_mode_code == WM_LATCH && plane_write_enables[2])
      |=> plane_bit_we[23:16] == 8'hff)
    else $error("latch copy masked");

  a_read_hold: assert property (@(posedge clock) disable iff (!rst_n)
    !mem_rd_strobe |=> $stable(cpu_rdata))
    else $error("read data not held");

  // every plane stays shut while its sequencer enable is low
  for (genvar g = 0; g < 4; g++)
  begin : g_gate
    a_gate_each: assert property (@(posedge clock) disable iff (!rst_n)
      !plane_write_enables[g] |=> plane_bit_we[8*g +: 8] == 8'h00)
      else $error("disabled plane enabled");
  end

endmodule : plane_datapath

// *** plane_memory_model.sv ***
// behavioural four-plane display memory seen at one cpu address
// assumes the datapath gives per-bit enables and a one-cycle write pulse
`timescale 1ns/1ps
module plane_memory_model
(
  input  wire logic        clock,
  input  wire logic [31:0] plane_wdata,
  input  wire logic [31:0] plane_bit_we,
  input  wire logic        plane_wr_pulse,
  input  wire logic        mem_rd_strobe,
  output logic      [31:0] plane_rdata
);
  logic [31:0] mem = 32'h0000_0000;

  // only enabled bits change, the rest keep old contents
  always_ff @(posedge clock)
  begin
    if (plane_wr_pulse)
      mem <= (mem & ~plane_bit_we) | (plane_wdata & plane_bit_we);
  end

  // read bus is only valid with the strobe; inverted otherwise so stale data never passes
  assign plane_rdata = mem_rd_strobe ? mem : ~mem;
endmodule : plane_memory_model

// *** vga_plane_write_read_datapath_bench.sv ***
// self-checking bench for the plane write/read datapath
// assumes the memory model above stands on the plane side
`timescale 1ns/1ps
module vga_plane_write_read_datapath_bench;
  import gfx_datapath_pkg::*;
  logic        clock, rst_n, io_wr, io_rd, mem_wr_strobe, mem_rd_strobe;
  logic [15:0] io_addr;
  logic [7:0]  io_wdata, io_rdata, cpu_wdata, cpu_rdata;
  logic [31:0] plane_rdata, plane_wdata, plane_bit_we;
  logic [3:0]  plane_write_enables;
  logic        chain_four_setting, plane_wr_pulse;
  logic [1:0]  chain_plane;
  int          bad_count = 0;
  int          checks = 0;

  plane_datapath i_dut (.clock(clock), .rst_n(rst_n), .io_addr(io_addr),
    .io_wdata(io_wdata), .io_wr(io_wr), .io_rd(io_rd), .io_rdata(io_rdata),
    .mem_wr_strobe(mem_wr_strobe), .mem_rd_strobe(mem_rd_strobe),
    .cpu_wdata(cpu_wdata), .plane_rdata(plane_rdata),
    .plane_write_enables(plane_write_enables),
    .chain_four_setting(chain_four_setting), .chain_plane(chain_plane),
    .plane_wdata(plane_wdata), .plane_bit_we(plane_bit_we),
    .plane_wr_pulse(plane_wr_pulse), .cpu_rdata(cpu_rdata));

  plane_memory_model i_mem (.clock(clock), .plane_wdata(plane_wdata),
    .plane_bit_we(plane_bit_we), .plane_wr_pulse(plane_wr_pulse),
    .mem_rd_strobe(mem_rd_strobe), .plane_rdata(plane_rdata));

  // 100 MHz clock
  initial
  begin
    clock = 1'b0;
    forever #5 clock = ~clock;
  end

  task automatic check(input string name, input logic [7:0] exp, input logic [7:0] got);
    checks++;
    if (got !== exp)
    begin
      bad_count++;
      $display("unexpected %s expected %h seen %h", name, exp, got);
    end
  endtask : check

  task automatic end_of_test;
    $display("checks %0d mismatches %0d", checks, bad_count);
    if (bad_count == 0 && checks > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask : end_of_test

  // index cycle then data cycle, back to back
  task automatic io_write(input logic [3:0] idx, input logic [7:0] data);
    @(negedge clock);
    io_addr = INDEX_PORT; io_wdata = {4'h0, idx}; io_wr = 1'b1;
    @(negedge clock);
    io_addr = DATA_PORT; io_wdata = data;
    @(negedge clock);
    io_wr = 1'b0;
  endtask : io_write

  // register data stands for one cycle only, then returns to zero
  task automatic io_read(input logic [3:0] idx, input logic [7:0] exp);
    @(negedge clock);
    io_addr = INDEX_PORT; io_wdata = {4'h0, idx}; io_wr = 1'b1;
    @(negedge clock);
    io_wr = 1'b0; io_addr = DATA_PORT; io_rd = 1'b1;
    @(negedge clock);
    io_rd = 1'b0;
    check("io_rdata", exp, io_rdata);
    @(negedge clock);
    check("io_rdata idle", 8'h00, io_rdata);
  endtask : io_read

  task automatic mem_write(input logic [7:0] data);
    @(negedge clock);
    mem_wr_strobe = 1'b1; cpu_wdata = data;
    @(negedge clock);
    mem_wr_strobe = 1'b0;
  endtask : mem_write

  task automatic mem_read(input logic [7:0] exp);
    @(negedge clock);
    mem_rd_strobe = 1'b1;
    @(negedge clock);
    mem_rd_strobe = 1'b0;
    check("cpu_rdata", exp, cpu_rdata);
  endtask : mem_read

  task automatic read_plane(input logic [1:0] p, input logic [7:0] exp);
    io_write(IDX_READ_SELECT, {6'h00, p});
    mem_read(exp);
  endtask : read_plane

  function automatic logic [7:0] rotr(input logic [7:0] d, input logic [2:0] r);
    logic [15:0] w;
    w = {d, d} >> r;
    return w[7:0];
  endfunction : rotr

  // watchdog, far beyond the few hundred cycles the tests need
  initial
  begin
    #200000;
    bad_count++;
    end_of_test();
  end

  initial
  begin
    logic [7:0] fexp;
    logic [7:0] pexp [4];
    rst_n = 1'b0; io_addr = 16'h0000; io_wdata = 8'h00; io_wr = 1'b0; io_rd = 1'b0;
    mem_wr_strobe = 1'b0; mem_rd_strobe = 1'b0; cpu_wdata = 8'h00;
    plane_write_enables = 4'hf; chain_four_setting = 1'b0; chain_plane = 2'h0;
    repeat (2) @(negedge clock);
    rst_n = 1'b1;
    // register access, reset value, reserved bits and a refused index
    io_read(IDX_BIT_MASK, 8'hff);
    io_write(IDX_ROTATE_LOGIC, 8'hff);
    io_read(IDX_ROTATE_LOGIC, 8'h1f);
    io_read(4'h9, 8'h00);
    // every rotate count
    for (int r = 0; r < 8; r++)
    begin
      io_write(IDX_ROTATE_LOGIC, 8'(r));
      mem_write(8'h81);
      read_plane(2'(r), rotr(8'h81, 3'(r)));
    end
    // function codes against latches, applied after a rotate of 4
    for (int f = 1; f < 4; f++)
    begin
      io_write(IDX_ROTATE_LOGIC, 8'h00);
      mem_write(8'h0f);
      read_plane(2'h0, 8'h0f);
      io_write(IDX_ROTATE_LOGIC, 8'(f * 8 + 4));
      mem_write(8'hc3);
      fexp = (f == 1) ? 8'h0c : (f == 2) ? 8'h3f : 8'h33;
      read_plane(2'h1, fexp);
    end
    // fill on maps 0 and 1 with upper bits protected
    io_write(IDX_ROTATE_LOGIC, 8'h00);
    mem_write(8'h00);
    io_write(IDX_BIT_MASK, 8'h0f);
    io_write(IDX_FILL_VALUE, 8'h05);
    io_write(IDX_FILL_ENABLE, 8'h03);
    mem_write(8'ha5);
    pexp = '{8'h0f, 8'h00, 8'h05, 8'h05};
    for (int p = 0; p < 4; p++)
      read_plane(2'(p), pexp[p]);
    io_write(IDX_BIT_MASK, 8'hff);
    io_write(IDX_FILL_ENABLE, 8'h00);
    // only plane 2 enabled for writing
    mem_write(8'h00);
    plane_write_enables = 4'b0100;
    mem_write(8'h77);
    pexp = '{8'h00, 8'h00, 8'h77, 8'h00};
    for (int p = 0; p < 4; p++)
      read_plane(2'(p), pexp[p]);
    // latch copy restores plane 2 and ignores cpu data
    mem_write(8'h11);
    io_write(IDX_MODE, 8'h01);
    mem_write(8'hee);
    io_write(IDX_MODE, 8'h00);
    read_plane(2'h2, 8'h77);
    // compare read mode, read-map code parked on plane 3 which holds 00
    io_write(IDX_READ_SELECT, 8'h03);
    io_write(IDX_COMPARE_REF, 8'h04);
    io_write(IDX_MODE, 8'h08);
    mem_read(8'h77);
    io_write(IDX_COMPARE_REF, 8'h00);
    mem_read(8'h88);
    io_write(IDX_MODE, 8'h00);
    // chain-four overrides the read-map code
    chain_four_setting = 1'b1;
    chain_plane = 2'h2;
    read_plane(2'h0, 8'h77);
    chain_four_setting = 1'b0;
    plane_write_enables = 4'hf;
    // write mode 2 spreads cpu bit n over plane n, then xor with the latches
    io_write(IDX_MODE, 8'h02);
    mem_write(8'h05);
    pexp = '{8'hff, 8'h00, 8'hff, 8'h00};
    for (int p = 0; p < 4; p++)
      read_plane(2'(p), pexp[p]);
    io_write(IDX_ROTATE_LOGIC, 8'h18);
    mem_write(8'h03);
    pexp = '{8'h00, 8'hff, 8'hff, 8'h00};
    for (int p = 0; p < 4; p++)
      read_plane(2'(p), pexp[p]);
    // write mode 3: fill value through mask and rotated cpu data
    io_write(IDX_ROTATE_LOGIC, 8'h02);
    io_write(IDX_MODE, 8'h03);
    mem_write(8'h0f);
    io_write(IDX_MODE, 8'h00);
    pexp = '{8'hc3, 8'h3c, 8'hff, 8'h00};
    for (int p = 0; p < 4; p++)
      read_plane(2'(p), pexp[p]);
    end_of_test();
  end
endmodule : vga_plane_write_read_datapath_bench
